// ===== design/ddr3_timing_pkg.sv
// Constants and types for the DDR3 device timing block
`default_nettype none
package ddr3_timing_pkg;
    // System clock and timing figures
    localparam int CLK_PERIOD_PS = 100000;
    localparam int LEVEL_FB_MAX_PS = 7500;
    localparam int LEVEL_FB_RAW = LEVEL_FB_MAX_PS / CLK_PERIOD_PS;
    localparam int LEVEL_FB_CYCLES = (LEVEL_FB_RAW < 1) ? 1 : LEVEL_FB_RAW;
    localparam int REFRESH_RECOVERY_PS = 260000;
    localparam int REFRESH_OP_INT =
        (REFRESH_RECOVERY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] REFRESH_OP_CYCLES = 4'(REFRESH_OP_INT);
    localparam logic [3:0] ROW_OP_CYCLES = 4'h2;
    localparam logic [3:0] OP_IDLE = 4'h0;
    // Clocks after reset before pin edges are trusted
    localparam logic [1:0] SETTLE_DONE = 2'h3;

    // Counts of link clocks
    localparam logic [6:0] ZQ_SHORT_CLOCKS = 7'h40;
    localparam logic [6:0] ZQ_LAST = 7'h01;
    localparam logic [5:0] WR_TAIL_BURST8 = 6'h04;
    localparam logic [5:0] WR_TAIL_CHOP4 = 6'h02;
    localparam logic [5:0] WR_LAST = 6'h01;

    // Pin vector layout after synchronisation
    localparam int PIN_W = 8;
    localparam int PIN_CK = 0;
    localparam int PIN_CKE = 1;
    localparam int PIN_CS_N = 2;
    localparam int PIN_RAS_N = 3;
    localparam int PIN_CAS_N = 4;
    localparam int PIN_WE_N = 5;
    localparam int PIN_AP = 6;
    localparam int PIN_DQS = 7;

    // Commands as {ras_n, cas_n, we_n}
    typedef enum logic [2:0] {
        CMD_MRS = 3'h0,
        CMD_REF = 3'h1,
        CMD_PRE = 3'h2,
        CMD_ACT = 3'h3,
        CMD_WR = 3'h4,
        CMD_RD = 3'h5,
        CMD_ZQ = 3'h6,
        CMD_NOP = 3'h7
    } cmd_t;

    // Power-down state
    typedef enum logic [2:0] {
        PD_AWAKE = 3'h1,
        PD_DRAIN = 3'h2,
        PD_LOW = 3'h4
    } pd_state_t;

    typedef logic [4:0] latency_t;
endpackage
`default_nettype wire

// ===== design/pin_sync2.sv
// Two-flop synchroniser for a vector of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pins in, synchronised out
    input wire logic [W-1:0] pins,
    output logic [W-1:0] pins_s
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = pins;
        sync_d = meta_q;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign pins_s = sync_q;
endmodule
`default_nettype wire

// ===== design/ddr3_device_timing.sv
// DDR3 device-side power-down, write-start, leveling and ZQ timing
`timescale 1ns/1ps
`default_nettype none
module ddr3_device_timing
    import ddr3_timing_pkg::*;
(
    // System clock and reset
    input wire logic clock,
    input wire logic rst,
    // Link pins from the controller
    input wire logic link_clk,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic addr_ap,
    input wire logic dqs,
    // Leveling feedback on the data pin
    output logic level_dq_o,
    output logic level_dq_oe,
    // Mode settings
    input wire ddr3_timing_pkg::latency_t write_latency_clocks,
    input wire logic chop4_fixed_by_mode,
    input wire logic leveling_mode,
    // Status
    output logic write_start,
    output logic low_power,
    output logic op_busy,
    output logic zq_busy,
    output logic zq_done
);
    import ddr3_timing_pkg::*;

    logic [PIN_W-1:0] pins_s;
    logic ck_s, cke_s, cs_n_s, ap_s, dqs_s;
    cmd_t cmd;
    logic ck_rise, dqs_rise, cmd_valid, armed;

    logic ck_prev_q, ck_prev_d, dqs_prev_q, dqs_prev_d;
    pd_state_t pd_q, pd_d;
    logic [3:0] op_cnt_q, op_cnt_d;
    logic op_busy_q, op_busy_d;
    logic low_power_q, low_power_d;
    logic [5:0] wr_cnt_q, wr_cnt_d;
    logic wr_pend_q, wr_pend_d;
    logic write_start_q, write_start_d;
    logic [6:0] zq_cnt_q, zq_cnt_d;
    logic zq_busy_q, zq_busy_d;
    logic zq_done_q, zq_done_d;
    logic level_dq_q, level_dq_d;
    logic level_oe_q, level_oe_d;
    logic [1:0] settle_q, settle_d;

    pin_sync2 #(.W(PIN_W)) u_sync (
        .clock(clock),
        .rst(rst),
        .pins({dqs, addr_ap, we_n, cas_n, ras_n, cs_n, cke, link_clk}),
        .pins_s(pins_s)
    );

    assign ck_s = pins_s[PIN_CK];
    assign cke_s = pins_s[PIN_CKE];
    assign cs_n_s = pins_s[PIN_CS_N];
    assign ap_s = pins_s[PIN_AP];
    assign dqs_s = pins_s[PIN_DQS];
    assign cmd = cmd_t'({pins_s[PIN_RAS_N], pins_s[PIN_CAS_N],
                         pins_s[PIN_WE_N]});
    // A pin already high at reset release must not look like a fresh edge
    assign armed = (settle_q == SETTLE_DONE);
    assign ck_rise = ck_s & ~ck_prev_q & armed;
    assign dqs_rise = dqs_s & ~dqs_prev_q & armed;
    // Commands are taken only on a link rising edge with clock enable high
    assign cmd_valid = ck_rise & cke_s & ~cs_n_s;

    always_comb begin
        ck_prev_d = ck_s;
        dqs_prev_d = dqs_s;
        settle_d = armed ? settle_q : settle_q + 2'h1;
        pd_d = pd_q;
        op_cnt_d = op_cnt_q;
        wr_cnt_d = wr_cnt_q;
        wr_pend_d = wr_pend_q;
        write_start_d = 1'b0;
        zq_cnt_d = zq_cnt_q;
        zq_busy_d = zq_busy_q;
        zq_done_d = 1'b0;
        level_dq_d = level_dq_q;
        level_oe_d = leveling_mode;

        // Row, precharge and refresh operations run on the system clock
        if (op_cnt_q != OP_IDLE) begin
            op_cnt_d = op_cnt_q - 4'h1;
        end
        if (cmd_valid) begin
            unique case (cmd)
                CMD_ACT, CMD_PRE: op_cnt_d = ROW_OP_CYCLES;
                CMD_REF: op_cnt_d = REFRESH_OP_CYCLES;
                default: ;
            endcase
        end

        // Internal write start counted in link clocks
        if (ck_rise && wr_pend_q) begin
            wr_cnt_d = wr_cnt_q - 6'h01;
            if (wr_cnt_q == WR_LAST) begin
                write_start_d = 1'b1;
                wr_pend_d = 1'b0;
            end
        end
        if (cmd_valid && cmd == CMD_WR) begin
            wr_pend_d = 1'b1;
            wr_cnt_d = {1'b0, write_latency_clocks} +
                (chop4_fixed_by_mode ? WR_TAIL_CHOP4 : WR_TAIL_BURST8);
        end

        // Short ZQ calibration window
        if (ck_rise && zq_busy_q) begin
            zq_cnt_d = zq_cnt_q - 7'h01;
            if (zq_cnt_q == ZQ_LAST) begin
                zq_busy_d = 1'b0;
                zq_done_d = 1'b1;
            end
        end
        if (cmd_valid && cmd == CMD_ZQ && !ap_s) begin
            zq_busy_d = 1'b1;
            zq_cnt_d = ZQ_SHORT_CLOCKS;
        end

        // Leveling: return sampled link clock level on strobe rise
        if (leveling_mode && dqs_rise) begin
            level_dq_d = ck_s;
        end

        // Power-down entry waits for the running operation
        unique case (pd_q)
            PD_AWAKE: begin
                if (ck_rise && !cke_s) begin
                    pd_d = (op_cnt_q != OP_IDLE) ? PD_DRAIN : PD_LOW;
                end
            end
            PD_DRAIN: begin
                if (ck_rise && cke_s) begin
                    pd_d = PD_AWAKE;
                end else if (op_cnt_q == OP_IDLE) begin
                    pd_d = PD_LOW;
                end
            end
            PD_LOW: begin
                if (ck_rise && cke_s) begin
                    pd_d = PD_AWAKE;
                end
            end
            default: pd_d = PD_AWAKE;
        endcase
        op_busy_d = (op_cnt_d != OP_IDLE);
        low_power_d = (pd_d == PD_LOW);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ck_prev_q <= 1'b0;
            settle_q <= '0;
            dqs_prev_q <= 1'b0;
            pd_q <= PD_AWAKE;
            op_cnt_q <= OP_IDLE;
            op_busy_q <= 1'b0;
            low_power_q <= 1'b0;
            wr_cnt_q <= '0;
            wr_pend_q <= 1'b0;
            write_start_q <= 1'b0;
            zq_cnt_q <= '0;
            zq_busy_q <= 1'b0;
            zq_done_q <= 1'b0;
            level_dq_q <= 1'b0;
            level_oe_q <= 1'b0;
        end else begin
            ck_prev_q <= ck_prev_d;
            settle_q <= settle_d;
            dqs_prev_q <= dqs_prev_d;
            pd_q <= pd_d;
            op_cnt_q <= op_cnt_d;
            op_busy_q <= op_busy_d;
            low_power_q <= low_power_d;
            wr_cnt_q <= wr_cnt_d;
            wr_pend_q <= wr_pend_d;
            write_start_q <= write_start_d;
            zq_cnt_q <= zq_cnt_d;
            zq_busy_q <= zq_busy_d;
            zq_done_q <= zq_done_d;
            level_dq_q <= level_dq_d;
            level_oe_q <= level_oe_d;
        end
    end

    assign level_dq_o = level_dq_q;
    assign level_dq_oe = level_oe_q;
    assign write_start = write_start_q;
    assign low_power = low_power_q;
    assign op_busy = op_busy_q;
    assign zq_busy = zq_busy_q;
    assign zq_done = zq_done_q;

    // Helper counters for the checks below
    logic [5:0] chk_wr_edges_q, chk_wr_target_q;
    logic [6:0] chk_zq_edges_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            chk_wr_edges_q <= '0;
            chk_wr_target_q <= '0;
            chk_zq_edges_q <= '0;
        end else begin
            if (cmd_valid && cmd == CMD_WR) begin
                chk_wr_edges_q <= '0;
                chk_wr_target_q <= wr_cnt_d;
            end else if (ck_rise) begin
                chk_wr_edges_q <= chk_wr_edges_q + 6'h01;
            end
            if (cmd_valid && cmd == CMD_ZQ && !ap_s) begin
                chk_zq_edges_q <= '0;
            end else if (ck_rise && zq_busy_q) begin
                chk_zq_edges_q <= chk_zq_edges_q + 7'h01;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_strobe_rise_leveling;
        leveling_mode && dqs_rise;
    endsequence

    sequence s_drain_entry;
        ck_rise && !cke_s && pd_q == PD_AWAKE && op_cnt_q != OP_IDLE;
    endsequence

    a_write_start_time: assert property (
        write_start_q |-> chk_wr_edges_q == chk_wr_target_q)
        else $error("internal write start at wrong link edge");

    a_write_start_pulse: assert property (
        write_start_q |=> !write_start_q)
        else $error("write start longer than one cycle");

    a_level_feedback: assert property (
        s_strobe_rise_leveling |-> ##1 level_dq_q == $past(ck_s))
        else $error("leveling feedback late or wrong");

    a_level_oe_off: assert property (
        !leveling_mode [*2] |-> !level_oe_q)
        else $error("data pin driven outside leveling");

    a_drain_accept: assert property (
        s_drain_entry |=> pd_q == PD_DRAIN && !low_power_q)
        else $error("clock enable low not held off during operation");

    a_drain_ends: assert property (
        pd_q == PD_DRAIN |-> ##[1:5] pd_q != PD_DRAIN)
        else $error("power-down drain does not finish");

    a_low_idle: assert property (
        low_power_q |-> !op_busy_q)
        else $error("low power while operation running");

    a_zq_length: assert property (
        $fell(zq_busy_q) |-> zq_done_q && chk_zq_edges_q == ZQ_SHORT_CLOCKS)
        else $error("short calibration not 64 link clocks");
endmodule
`default_nettype wire

// ===== sim/ddr3_ctrl_model.sv
// Controller-side model: free-running link clock and command pins
`timescale 1ns/1ps
`default_nettype none
module ddr3_ctrl_model (
    // Requests from the bench
    input wire ddr3_timing_pkg::cmd_t cmd_in,
    input wire logic cke_in,
    input wire logic ap_in,
    input wire logic dqs_in,
    // Mode settings the controller has programmed
    input wire ddr3_timing_pkg::latency_t wl_in,
    input wire logic chop_in,
    // Link pins
    output logic link_clk,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic addr_ap,
    output logic dqs
);
    import ddr3_timing_pkg::*;
    // Link clocks that must pass after a command before power-down
    localparam int READ_LATENCY_CLOCKS = 6;
    localparam int WRITE_RECOVERY_NS = 15;
    localparam int WRITE_RECOVERY_PROG = 8;
    localparam int MODE_UPDATE_CLOCKS = 12;
    localparam int LINK_PERIOD_NS = 800;
    localparam int WRITE_RECOVERY_CK =
        (WRITE_RECOVERY_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    int pd_wait_q = 0;
    initial begin
        link_clk = 1'b0;
        cke = 1'b0;
        {cs_n, ras_n, cas_n, we_n, addr_ap} = 5'h1f;
    end
    // Slow but steady clock is legal
    always #400 link_clk = ~link_clk;
    // Pins move on the falling edge, half a period before they are sampled
    always @(negedge link_clk) begin
        int tail;
        int need;
        tail = chop_in ? 2 : 4;
        case (cmd_in)
            CMD_ACT, CMD_PRE, CMD_REF: need = 1;
            CMD_RD: need = READ_LATENCY_CLOCKS + 5;
            CMD_WR: need = ap_in ? wl_in + tail + WRITE_RECOVERY_PROG + 1
                                 : wl_in + tail + WRITE_RECOVERY_CK;
            CMD_MRS: need = MODE_UPDATE_CLOCKS;
            default: need = 0;
        endcase
        // Largest outstanding wait gates power-down entry
        if (cke_in && need > pd_wait_q) begin
            pd_wait_q <= need;
        end else if (pd_wait_q > 0) begin
            pd_wait_q <= pd_wait_q - 1;
        end
        cke <= cke_in | (pd_wait_q > 1);
        cs_n <= (cmd_in == CMD_NOP);
        {ras_n, cas_n, we_n} <= cmd_in;
        addr_ap <= ap_in;
    end
    assign dqs = dqs_in;
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the device timing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ddr3_timing_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    cmd_t cmd_in = CMD_NOP;
    logic cke_in = 1'b1;
    logic ap_in = 1'b0;
    logic dqs_in = 1'b0;
    latency_t wl = 5'h05;
    logic chop = 1'b0;
    logic lvl = 1'b0;
    wire link_clk, cke, cs_n, ras_n, cas_n, we_n, addr_ap, dqs;
    logic level_dq_o, level_dq_oe, write_start, low_power;
    logic op_busy, zq_busy, zq_done;
    int err_count = 0;
    int n_compared = 0;

    always #50 clock = ~clock;

    ddr3_ctrl_model i_ctrl (.cmd_in(cmd_in), .cke_in(cke_in), .ap_in(ap_in),
        .dqs_in(dqs_in), .wl_in(wl), .chop_in(chop),
        .link_clk(link_clk), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr_ap(addr_ap),
        .dqs(dqs));
    ddr3_device_timing i_dut (.clock(clock), .rst(rst), .link_clk(link_clk),
        .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .addr_ap(addr_ap), .dqs(dqs), .level_dq_o(level_dq_o),
        .level_dq_oe(level_dq_oe), .write_latency_clocks(wl),
        .chop4_fixed_by_mode(chop), .leveling_mode(lvl),
        .write_start(write_start), .low_power(low_power),
        .op_busy(op_busy), .zq_busy(zq_busy), .zq_done(zq_done));

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    // One command on one link rise; counts busy cycles that follow it
    task automatic issue(input cmd_t c, input logic ap, output int busy);
        tick();
        cmd_in = c;
        ap_in = ap;
        // The model launches on a link fall; the device takes it on the rise
        @(negedge link_clk);
        @(posedge link_clk);
        tick();
        cmd_in = CMD_NOP;
        busy = 0;
        repeat (7) begin
            tick();
            if (op_busy === 1'b1) busy++;
        end
    endtask

    // Link rises seen until write_start (zq=0) or zq_done (zq=1)
    task automatic rises(input logic zq, output int n);
        logic prev;
        prev = link_clk;
        n = 0;
        for (int i = 0; i < 1000; i++) begin
            tick();
            if (link_clk && !prev) n++;
            prev = link_clk;
            if ((zq ? zq_done : write_start) === 1'b1) break;
        end
    endtask

    task automatic t_cmds();
        int b;
        cmd_t c;
        logic [7:0] e;
        for (int i = 0; i < 8; i++) begin
            c = cmd_t'(i);
            e = (c == CMD_REF) ? 8'h03 :
                (c == CMD_ACT || c == CMD_PRE) ? 8'h02 : 8'h00;
            issue(c, c == CMD_ZQ, b);
            chk("busy cycles", e, 8'(b));
            chk1("long zq ignored", 1'b0, zq_busy);
        end
    endtask

    task automatic t_write(input logic c4, input latency_t l);
        int n;
        int b;
        chop = c4;
        wl = l;
        issue(CMD_WR, 1'b0, b);
        rises(1'b0, n);
        chk("write_start rise", 8'(l) + (c4 ? 8'h02 : 8'h04), 8'(n));
        tick();
        chk1("write_start width", 1'b0, write_start);
    endtask

    task automatic t_zq();
        int n;
        int b;
        issue(CMD_ZQ, 1'b0, b);
        chk1("zq_busy", 1'b1, zq_busy);
        rises(1'b1, n);
        chk("zq rises", 8'h40, 8'(n));
        tick();
        chk1("zq_busy end", 1'b0, zq_busy);
        chk1("zq_done width", 1'b0, zq_done);
    endtask

    task automatic t_pd();
        int b;
        issue(CMD_REF, 1'b0, b);
        chk("refresh busy", 8'h03, 8'(b));
        cke_in = 1'b0;
        repeat (4) @(posedge link_clk);
        tick(5);
        chk1("low_power", 1'b1, low_power);
        issue(CMD_ACT, 1'b0, b);
        chk("act while low", 8'h00, 8'(b));
        cke_in = 1'b1;
        repeat (2) @(posedge link_clk);
        tick(5);
        chk1("low_power exit", 1'b0, low_power);
    endtask

    task automatic t_level();
        chk1("oe idle", 1'b0, level_dq_oe);
        lvl = 1'b1;
        tick(2);
        chk1("oe on", 1'b1, level_dq_oe);
        repeat (40) @(posedge link_clk);
        for (int k = 0; k < 2; k++) begin
            if (k == 0) @(posedge link_clk);
            else @(negedge link_clk);
            tick(2);
            dqs_in = 1'b1;
            tick(5);
            chk1("level feedback", k == 0, level_dq_o);
            dqs_in = 1'b0;
        end
        lvl = 1'b0;
        tick(2);
        chk1("oe off", 1'b0, level_dq_oe);
        @(posedge link_clk);
        tick(2);
        dqs_in = 1'b1;
        tick(5);
        chk1("dqs ignored", 1'b0, level_dq_o);
        dqs_in = 1'b0;
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        tick(4);
        rst = 1'b0;
        tick(3);
        chk("reset outputs", 8'h00, {1'b0, level_dq_o, level_dq_oe,
            write_start, low_power, op_busy, zq_busy, zq_done});
        t_cmds();
        t_write(1'b0, 5'h05);
        t_write(1'b1, 5'h03);
        t_zq();
        t_pd();
        t_level();
        stop_test();
    end

    initial begin
        #600000;
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
